// [hw/acu_cfg.svh]
`ifndef ACU_CFG_SVH
`define ACU_CFG_SVH
`define ACU_AW 24
`define ACU_PAW 21
`define ACU_MW 16
`define ACU_NPTR 6
`define ACU_SEC_PTR 3
`define ACU_MOD_LINEAR 16'hFFFF
`define ACU_PERIPH_BASE_RST 24'h00_FFC0
`define ACU_PERIPH_RSV_FIRST 6'h34
`define ACU_STACK_RST 24'h00_0000
`define ACU_REG_WR 5'h00
`define ACU_REG_RD 5'h01
`define ACU_REG_SEL 5'h02
`define ACU_REG_SHD 5'h03
`define ACU_REG_BASE 5'h04
`define ACU_REG_STAT 5'h05
`endif

// [hw/acu_pkg.sv]
`include "acu_cfg.svh"
package acu_pkg;
   typedef enum logic [1:0] {ACU_SZ_BYTE = 2'h0, ACU_SZ_WORD = 2'h1, ACU_SZ_LONG = 2'h2} acu_size_t;
   typedef enum logic [2:0] {ACU_EA_PLAIN = 3'h0, ACU_EA_POSTINC = 3'h1, ACU_EA_POSTDEC = 3'h2,
      ACU_EA_POSTN = 3'h3, ACU_EA_INDEXN = 3'h4, ACU_EA_PERIPH = 3'h5, ACU_EA_SHORT = 3'h6} acu_mode_t;
   // primary request: one per instruction cycle
   typedef struct packed {
      logic valid;
      logic toProgram;
      logic [2:0] reg_sel;
      acu_mode_t mode;
      acu_size_t size;
      logic useOffsetOnly;
      logic [5:0] shortAddr;
   } acu_preq_t;
   typedef struct packed {
      logic valid;
      logic postInc;
      logic useOffsetOnly;
   } acu_sreq_t;
   typedef struct packed {
      logic valid;
      logic [`ACU_AW-1:0] addr;
      acu_size_t size;
      logic periphReserved;
   } acu_bus_t;
   typedef struct packed {
      logic [`ACU_NPTR:0][`ACU_AW-1:0] gpr;
      logic [`ACU_MW-1:0] offsetOnly;
      logic [`ACU_MW-1:0] modifierSelect;
      logic [`ACU_AW-1:0] stackPointer;
   } acu_regs_t;
endpackage

// [hw/address_calc_unit.sv]
// Behaviour
// - two address ALUs give up to two 24-bit addresses each cycle
// - data buses span 16M words, program bus 2M words
// - primary bus carries byte/word/long sizes; others words only
// - seven 24-bit general registers: six pointers plus one offset
// - secondary bus address always comes from pointer three
// - first offset also a pointer; 16-bit second offset only an offset
// - 16-bit modifier picks linear or modulo update arithmetic
// - base variant shadows four registers, extended variant nine
// - separate 24-bit stack pointer register
// - a 24-bit adder plus a separate 24-bit modulo unit
// - addresses computed in parallel with other units, no stall
// - peripheral short mode reaches relocatable 64-location window
// - top 12 window locations reserved for core configuration
// - short absolute mode reaches lowest 64 data locations
// - program bus addresses fetches; program writes use write data bus
// - second 16-bit read in parallel on secondary bus
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`include "acu_cfg.svh"

module address_calc_unit
   import acu_pkg::*;
#(
   parameter bit EXTENDED = 1'b1
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire acu_pkg::acu_preq_t primaryReq,
   input wire acu_pkg::acu_sreq_t secondaryReq,
   input wire logic shadowSwap,
   input wire logic spPush,
   input wire logic spPop,
   input wire logic [4:0] regAddr,
   input wire logic [23:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output acu_pkg::acu_bus_t primary_data_addr_bus,
   output acu_pkg::acu_bus_t program_addr_bus,
   output acu_pkg::acu_bus_t secondary_data_addr_bus,
   output logic programWrite,
   output logic [23:0] stack_pointer_reg,
   output logic [23:0] regRdata
);
   import acu_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      acu_regs_t r;
      acu_regs_t shd;
      logic [2:0] sel;
      logic [`ACU_AW-1:0] periphBase;
      acu_bus_t pri;
      acu_bus_t prg;
      acu_bus_t sec;
      logic prgWr;
      logic [`ACU_AW-1:0] rdata;
   } acu_state_t;

   acu_state_t s_q;
   acu_state_t s_d;

   // ****************************************
   // arithmetic
   // ****************************************
   // modulo update: wraps inside the aligned buffer of size mod+1
   function automatic logic [`ACU_AW-1:0] upd(input logic [`ACU_AW-1:0] base,
                                             input logic [`ACU_AW-1:0] step,
                                             input logic [`ACU_MW-1:0] mods);
      logic [`ACU_AW-1:0] sum;
      logic [`ACU_AW-1:0] lo;
      logic [`ACU_AW-1:0] msk;
      logic [`ACU_AW-1:0] ext;
      logic under;
      logic over;
      sum = base + step;
      msk = {8'h00, mods};
      ext = msk + 24'h00_0001;
      lo = (base & msk) + step;
      // leaving the buffer below wraps up by its size, leaving above wraps down
      under = step[`ACU_AW-1] && (lo[`ACU_AW-1] || ((base & msk) < (24'h00_0000 - step)));
      over = !step[`ACU_AW-1] && (lo > msk);
      if (mods == `ACU_MOD_LINEAR)
         upd = sum;
      else
      begin
         // modulo unit, valid for steps smaller than the buffer
         if (under)
            lo = lo + ext;
         else if (over)
            lo = lo - ext;
         upd = (base & ~msk) | (lo & msk);
      end
   endfunction

   function automatic logic [`ACU_AW-1:0] sz_step(input acu_size_t sz);
      sz_step = (sz == ACU_SZ_LONG) ? 24'h00_0002 : 24'h00_0001;
   endfunction

   function automatic logic [`ACU_AW-1:0] sx16(input logic [`ACU_MW-1:0] v);
      sx16 = {{8{v[`ACU_MW-1]}}, v};
   endfunction

   // ****************************************
   // register decode
   // ****************************************
   // select code 7 has no general register behind it: read as zero, not unknown
   function automatic logic [`ACU_AW-1:0] pick_gpr(input acu_regs_t regs,
                                                  input logic [2:0] idx);
      pick_gpr = '0;
      if (idx <= 3'(`ACU_NPTR))
         pick_gpr = regs.gpr[idx];
   endfunction

   // select code 7 reaches the 16-bit offset-only register
   function automatic logic [`ACU_AW-1:0] sel_read(input acu_regs_t regs,
                                                  input logic [2:0] idx);
      sel_read = (idx == 3'h7) ? {8'h00, regs.offsetOnly} : pick_gpr(regs, idx);
   endfunction

   // core configuration slots sit at the top of the window
   function automatic logic rsv_slot(input logic [`ACU_AW-1:0] addr,
                                     input logic [`ACU_AW-1:0] base);
      logic [5:0] slot;
      slot = addr[5:0] - base[5:0];
      rsv_slot = (addr[`ACU_AW-1:6] == base[`ACU_AW-1:6]) && (slot >= `ACU_PERIPH_RSV_FIRST);
   endfunction

   always_comb
   begin
      logic [`ACU_AW-1:0] ptr;
      logic [`ACU_AW-1:0] off;
      logic [`ACU_AW-1:0] ea;
      logic [`ACU_AW-1:0] nxt;
      logic [`ACU_AW-1:0] sptr;
      logic [`ACU_AW-1:0] sstep;
      ptr = '0;
      off = '0;
      ea = '0;
      nxt = '0;
      sptr = '0;
      sstep = '0;
      s_d = s_q;
      s_d.pri.valid = 1'b0;
      s_d.prg.valid = 1'b0;
      s_d.sec.valid = 1'b0;
      s_d.prgWr = 1'b0;

      // ****************************************
      // primary or program address ALU
      // ****************************************
      ptr = pick_gpr(s_q.r, primaryReq.reg_sel);
      off = primaryReq.useOffsetOnly ? sx16(s_q.r.offsetOnly) : s_q.r.gpr[`ACU_NPTR];
      ea = ptr;
      nxt = ptr;
      unique case (primaryReq.mode)
         ACU_EA_PLAIN: ea = ptr;
         ACU_EA_POSTINC: nxt = upd(ptr, sz_step(primaryReq.size), s_q.r.modifierSelect);
         ACU_EA_POSTDEC: nxt = upd(ptr, 24'h00_0000 - sz_step(primaryReq.size), s_q.r.modifierSelect);
         ACU_EA_POSTN: nxt = upd(ptr, off, s_q.r.modifierSelect);
         ACU_EA_INDEXN: ea = upd(ptr, off, s_q.r.modifierSelect);
         ACU_EA_PERIPH: ea = s_q.periphBase | {18'h0_0000, primaryReq.shortAddr};
         ACU_EA_SHORT: ea = {18'h0_0000, primaryReq.shortAddr};
         default: ea = ptr;
      endcase
      if (primaryReq.valid)
      begin
         if (primaryReq.toProgram)
         begin
            // program side is word only, 21 address bits
            s_d.prg.valid = 1'b1;
            s_d.prg.addr = {3'h0, ea[`ACU_PAW-1:0]};
            s_d.prg.size = ACU_SZ_WORD;
            s_d.prg.periphReserved = 1'b0;
            s_d.prgWr = regWr;
         end
         else
         begin
            s_d.pri.valid = 1'b1;
            s_d.pri.addr = ea;
            s_d.pri.size = primaryReq.size;
            s_d.pri.periphReserved = rsv_slot(ea, s_q.periphBase);
         end
         if ((primaryReq.mode inside {ACU_EA_POSTINC, ACU_EA_POSTDEC, ACU_EA_POSTN})
             && (primaryReq.reg_sel <= 3'(`ACU_NPTR)))
            s_d.r.gpr[primaryReq.reg_sel] = nxt;
      end

      // ****************************************
      // secondary address ALU, in parallel
      // ****************************************
      sptr = s_q.r.gpr[`ACU_SEC_PTR];
      if (secondaryReq.valid)
      begin
         s_d.sec.valid = 1'b1;
         s_d.sec.addr = sptr;
         s_d.sec.size = ACU_SZ_WORD;
         s_d.sec.periphReserved = 1'b0;
         // second ALU runs beside the first; assigned after it, it wins over the first ALU on pointer three (register port and extended-variant swap override)
         sstep = secondaryReq.postInc ? 24'h00_0001 : sx16(s_q.r.offsetOnly);
         s_d.r.gpr[`ACU_SEC_PTR] = upd(sptr, sstep, s_q.r.modifierSelect);
      end

      // ****************************************
      // stack pointer
      // ****************************************
      if (spPush && !spPop)
         s_d.r.stackPointer = s_q.r.stackPointer + 24'h00_0001;
      else if (spPop && !spPush)
         s_d.r.stackPointer = s_q.r.stackPointer - 24'h00_0001;

      // ****************************************
      // register port
      // ****************************************
      if (regWr)
      begin
         unique case (regAddr)
            `ACU_REG_SEL: s_d.sel = regWdata[2:0];
            `ACU_REG_BASE: s_d.periphBase = {regWdata[`ACU_AW-1:6], 6'h00};
            `ACU_REG_WR:
               unique case (s_q.sel)
                  3'h7: s_d.r.offsetOnly = regWdata[`ACU_MW-1:0];
                  default:
                     if (s_q.sel == 3'h6 && regWdata[23])
                        s_d.r.modifierSelect = regWdata[`ACU_MW-1:0];
                     else
                        s_d.r.gpr[s_q.sel] = regWdata;
               endcase
            `ACU_REG_SHD: s_d.r.stackPointer = regWdata;
            default: ;
         endcase
      end

      // ****************************************
      // shadow swap
      // ****************************************
      // fast interrupt swap: base variant keeps only first two pointers, offset, modifier
      if (shadowSwap)
      begin
         s_d.r.modifierSelect = s_q.shd.modifierSelect;
         s_d.shd.modifierSelect = s_q.r.modifierSelect;
         s_d.r.gpr[`ACU_NPTR] = s_q.shd.gpr[`ACU_NPTR];
         s_d.shd.gpr[`ACU_NPTR] = s_q.r.gpr[`ACU_NPTR];
         for (int i = 0; i < `ACU_NPTR; i++)
            if (EXTENDED || i < 2)
            begin
               s_d.r.gpr[i] = s_q.shd.gpr[i];
               s_d.shd.gpr[i] = s_q.r.gpr[i];
            end
         if (EXTENDED)
         begin
            s_d.r.offsetOnly = s_q.shd.offsetOnly;
            s_d.shd.offsetOnly = s_q.r.offsetOnly;
         end
      end

      // ****************************************
      // read data
      // ****************************************
      s_d.rdata = '0;
      if (regRd)
      begin
         unique case (regAddr)
            `ACU_REG_RD: s_d.rdata = sel_read(s_q.r, s_q.sel);
            `ACU_REG_SEL: s_d.rdata = {21'h00_0000, s_q.sel};
            `ACU_REG_SHD: s_d.rdata = s_q.r.stackPointer;
            `ACU_REG_BASE: s_d.rdata = s_q.periphBase;
            `ACU_REG_STAT: s_d.rdata = {8'h00, s_q.r.modifierSelect};
            default: s_d.rdata = '0;
         endcase
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_q <= '0;
         s_q.r.modifierSelect <= `ACU_MOD_LINEAR;
         s_q.shd.modifierSelect <= `ACU_MOD_LINEAR;
         s_q.r.stackPointer <= `ACU_STACK_RST;
         s_q.periphBase <= `ACU_PERIPH_BASE_RST;
      end
      else if (clkEn)
         s_q <= s_d;
   end

   // ****************************************
   // outputs
   // ****************************************
   assign primary_data_addr_bus = s_q.pri;
   assign program_addr_bus = s_q.prg;
   assign secondary_data_addr_bus = s_q.sec;
   assign programWrite = s_q.prgWr;
   assign stack_pointer_reg = s_q.r.stackPointer;
   assign regRdata = s_q.rdata;
endmodule

// [verification/acu_mem_model.sv]
module acu_mem_model
   import acu_pkg::*;
(
   input wire acu_pkg::acu_bus_t secBus,
   output logic [15:0] secRd
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle cycles show an inverted pattern so stale data never matches
   assign secRd = (secBus.addr[15:0] ^ 16'h5A5A) ^ {16{!secBus.valid}};
endmodule

// [verification/acu_calc_properties.sv]
module acu_calc_properties
   import acu_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire acu_pkg::acu_preq_t primaryReq,
   input wire acu_pkg::acu_sreq_t secondaryReq,
   input wire logic spPush,
   input wire logic spPop,
   input wire logic regWr,
   input wire logic regRd,
   input wire acu_pkg::acu_bus_t primary_data_addr_bus,
   input wire acu_pkg::acu_bus_t program_addr_bus,
   input wire acu_pkg::acu_bus_t secondary_data_addr_bus,
   input wire logic [23:0] stack_pointer_reg,
   input wire logic [23:0] regRdata
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic dTake;
   assign dTake = clkEn && primaryReq.valid && !primaryReq.toProgram;
   property p_prim;
      dTake |=> primary_data_addr_bus.valid && !program_addr_bus.valid;
   endproperty
   a_prim: assert property (p_prim) else $error("primary bus missed request");
   property p_prog;
      clkEn && primaryReq.valid && primaryReq.toProgram
      |=> program_addr_bus.valid && program_addr_bus.addr[23:21] == 3'h0;
   endproperty
   a_prog: assert property (p_prog) else $error("program bus wrong");
   property p_word;
      (!program_addr_bus.valid || program_addr_bus.size == ACU_SZ_WORD)
      && (!secondary_data_addr_bus.valid || secondary_data_addr_bus.size == ACU_SZ_WORD);
   endproperty
   a_word: assert property (p_word) else $error("non-word size on word bus");
   property p_sec;
      clkEn && secondaryReq.valid |=> secondary_data_addr_bus.valid;
   endproperty
   a_sec: assert property (p_sec) else $error("secondary bus missed request");
   property p_short;
      dTake && primaryReq.mode == ACU_EA_SHORT
      |=> primary_data_addr_bus.addr == {18'h0, $past(primaryReq.shortAddr)};
   endproperty
   a_short: assert property (p_short) else $error("short address wrong");
   property p_rsv;
      dTake && primaryReq.mode == ACU_EA_PERIPH
      |=> primary_data_addr_bus.periphReserved == ($past(primaryReq.shortAddr) >= 6'h34);
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
   property p_rdata;
      clkEn && !regRd |=> regRdata == '0;
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
   property p_push;
      clkEn && spPush && !spPop && !regWr |=> stack_pointer_reg == $past(stack_pointer_reg) + 24'h1;
   endproperty
   a_push: assert property (p_push) else $error("stack push wrong");
   property p_hold;
      (!clkEn || spPush == spPop) && !regWr |=> $stable(stack_pointer_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("stack pointer moved");
endmodule
bind address_calc_unit acu_calc_properties u_acu_calc_properties (.clk(clk), .nrst(nrst), .clkEn(clkEn),
   .primaryReq(primaryReq), .secondaryReq(secondaryReq), .spPush(spPush), .spPop(spPop), .regWr(regWr),
   .regRd(regRd), .primary_data_addr_bus(primary_data_addr_bus), .program_addr_bus(program_addr_bus),
   .secondary_data_addr_bus(secondary_data_addr_bus), .stack_pointer_reg(stack_pointer_reg), .regRdata(regRdata));

// [verification/address_calc_unit_tb.sv]
module address_calc_unit_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import acu_pkg::*;
   logic clk = 0, nrst = 0, clkEn = 1, shadowSwap = 0, spPush = 0, spPop = 0, regWr = 0, regRd = 0;
   logic [4:0] regAddr = '0;
   logic [23:0] regWdata = '0, spReg, rdata;
   acu_preq_t primaryReq = '0;
   acu_sreq_t secondaryReq = '0;
   acu_preq_t preq;
   acu_bus_t pBus, progBus, sBus;
   logic progWr;
   logic [15:0] secRd;
   logic [5:0] sv [3] = '{6'h33, 6'h34, 6'h3F};
   int mismatches = 0, cmp_count = 0;
   always #5 clk = ~clk;
   address_calc_unit #(.EXTENDED(1'b1)) u_address_calc_unit (.clk(clk), .nrst(nrst), .clkEn(clkEn),
      .primaryReq(primaryReq), .secondaryReq(secondaryReq), .shadowSwap(shadowSwap), .spPush(spPush),
      .spPop(spPop), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .primary_data_addr_bus(pBus), .program_addr_bus(progBus), .secondary_data_addr_bus(sBus),
      .programWrite(progWr), .stack_pointer_reg(spReg), .regRdata(rdata));
   acu_mem_model u_acu_mem_model (.secBus(sBus), .secRd(secRd));
   // ********************
   // access tasks
   // ********************
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
      cmp_count++;
      if (s !== e)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [23:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [23:0] e);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask
   task automatic setr(input logic [2:0] s, input logic [23:0] d);
      wr(5'h02, {21'h0, s});
      wr(5'h00, d);
   endtask
   task automatic getr(input logic [2:0] s, input logic [23:0] e);
      wr(5'h02, {21'h0, s});
      rd(5'h01, e);
   endtask
   function automatic acu_preq_t mk(logic tp, logic [2:0] s, acu_mode_t m, acu_size_t z, logic [5:0] a);
      mk = '{1'b1, tp, s, m, z, 1'b0, a};
   endfunction
   task automatic pr(input acu_preq_t r, input logic [23:0] e);
      @(posedge clk);
      primaryReq <= r;
      @(posedge clk);
      primaryReq <= '0;
      #1 chk("abus", e, r.toProgram ? progBus.addr : pBus.addr);
      chk("asize", 24'(r.toProgram ? ACU_SZ_WORD : r.size), 24'(r.toProgram ? progBus.size : pBus.size));
      chk("pwr", '0, 24'(progWr));
   endtask
   task automatic step(input logic u, input logic d, input logic e, input logic w);
      @(posedge clk);
      spPush <= u;
      spPop <= d;
      clkEn <= e;
      shadowSwap <= w;
      @(posedge clk);
      spPush <= 1'b0;
      spPop <= 1'b0;
      clkEn <= 1'b1;
      shadowSwap <= 1'b0;
   endtask
   task automatic give_verdict;
      $display("mismatches %0d compares %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ********************
   // tests
   // ********************
   initial
   begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      rd(5'h05, 24'h00_FFFF);
      rd(5'h04, 24'h00_FFC0);
      rd(5'h1F, '0);
      chk("sp", '0, spReg);
      // top bit kept clear: with select 6 it would steer the write to the modifier
      for (int i = 0; i < 7; i++)
         setr(3'(i), 24'h25_0000 + 24'(i));
      for (int i = 0; i < 7; i++)
         getr(3'(i), 24'h25_0000 + 24'(i));
      pr(mk(0, 3'h0, ACU_EA_POSTINC, ACU_SZ_LONG, '0), 24'h25_0000);
      getr(3'h0, 24'h25_0002);
      pr(mk(1, 3'h1, ACU_EA_PLAIN, ACU_SZ_WORD, '0), 24'h05_0001);
      @(posedge clk);
      primaryReq <= mk(1, 3'h1, ACU_EA_PLAIN, ACU_SZ_WORD, '0);
      regAddr <= 5'h1F;
      regWr <= 1'b1;
      @(posedge clk);
      primaryReq <= '0;
      regWr <= 1'b0;
      #1 chk("pwr", 24'h00_0001, 24'(progWr));
      pr(mk(0, 3'h0, ACU_EA_SHORT, ACU_SZ_WORD, 6'h3F), 24'h00_003F);
      for (int i = 0; i < 3; i++)
      begin
         pr(mk(0, 3'h0, ACU_EA_PERIPH, ACU_SZ_WORD, sv[i]), {18'h03FF, sv[i]});
         chk("rsv", 24'(sv[i] >= 6'h34), 24'(pBus.periphReserved));
      end
      @(posedge clk);
      secondaryReq <= '{1'b1, 1'b1, 1'b0};
      @(posedge clk);
      secondaryReq <= '0;
      #1 chk("sbus", 24'h25_0003, sBus.addr);
      chk("srd", 24'h00_5A59, 24'(secRd));
      getr(3'h3, 24'h25_0004);
      pr(mk(0, 3'h4, ACU_EA_POSTDEC, ACU_SZ_BYTE, '0), 24'h25_0004);
      getr(3'h4, 24'h25_0003);
      pr(mk(0, 3'h1, ACU_EA_INDEXN, ACU_SZ_WORD, '0), 24'h4A_0007);
      pr(mk(0, 3'h5, ACU_EA_POSTN, ACU_SZ_WORD, '0), 24'h25_0005);
      getr(3'h5, 24'h4A_000B);
      setr(3'h7, 24'h00_FFFE);
      getr(3'h7, 24'h00_FFFE);
      preq = mk(0, 3'h2, ACU_EA_INDEXN, ACU_SZ_WORD, '0);
      preq.useOffsetOnly = 1'b1;
      pr(preq, 24'h25_0000);
      // modifier 3 means a four-word buffer
      setr(3'h6, 24'h80_0003);
      rd(5'h05, 24'h00_0003);
      setr(3'h2, 24'h00_0103);
      pr(mk(0, 3'h2, ACU_EA_POSTINC, ACU_SZ_WORD, '0), 24'h00_0103);
      getr(3'h2, 24'h00_0100);
      for (int i = 0; i < 6; i += 5)
      begin
         setr(3'(i), 24'h12_3456);
         step(0, 0, 1, 1);
         setr(3'(i), 24'h65_4321);
         step(0, 0, 1, 1);
         getr(3'(i), 24'h12_3456);
      end
      step(1, 0, 1, 0);
      step(1, 0, 1, 0);
      step(0, 1, 1, 0);
      step(1, 0, 0, 0);
      step(1, 1, 1, 0);
      rd(5'h03, 24'h00_0001);
      give_verdict();
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
endmodule
